// ### bmf_device.sv
/*
 bus-matching fifo device: storage, width conversion, flags, offset registers.
 assumes pins synchronous to ref_clk and config pins steady after master reset.
*/
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "bmf_params.svh"
module bmf_device #(
    parameter int DEPTH = `BMF_DEPTH
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    bmf_pins_if.dev                     pins,
    output logic [$clog2(DEPTH+1)-1:0]  stored_words,
    output bmf_pkg::bmf_width_t         write_port_width,
    output bmf_pkg::bmf_width_t         read_port_width
);
    import bmf_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [35:0]   mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] eoff_r;
    logic [CW-1:0] foff_r;
    logic [1:0]    widx_r;
    logic [1:0]    ridx_r;
    logic [35:0]   asm_r;
    logic [35:0]   dout_r;
    logic          ov_r;
    logic          woff_sel_r;
    logic          roff_sel_r;
    logic          ft_r;
    logic          be_r;
    logic          ip_r;
    logic          serial_r;
    bmf_width_t    ww_r;
    bmf_width_t    rw_r;
    logic          in_mrs;
    logic          wr_req;
    logic          rd_req;
    logic          is_full;
    logic          is_empty;
    logic          wr_last;
    logic          rd_last;
    logic          push;
    logic          fetch;
    logic          pop;
    logic [35:0]   asm_nxt;
    logic [31:0]   poff;

    function automatic bmf_width_t wsel(input logic bm, input logic iw, input logic ow, input logic rd);
        if (!bm)
            return BMF_X36;
        if (rd)
            return iw ? BMF_X36 : (ow ? BMF_X9 : BMF_X18);
        return !iw ? BMF_X36 : (ow ? BMF_X9 : BMF_X18);
    endfunction : wsel

    function automatic logic [1:0] piece_pos(input bmf_width_t w, input logic [1:0] idx, input logic le);
        logic [1:0] last;
        last = (w == BMF_X36) ? 2'h0 : ((w == BMF_X18) ? 2'h1 : 2'h3);
        return le ? idx : (last - idx);
    endfunction : piece_pos

    function automatic int piece_w(input bmf_width_t w);
        return (w == BMF_X36) ? 36 : ((w == BMF_X18) ? 18 : 9);
    endfunction : piece_w

    function automatic logic [CW-1:0] def_off(input logic [2:0] sel);
        int v;
        v = 0;
        unique case (sel)
            3'h0: v = `BMF_DEF_OFF0;
            3'h1: v = `BMF_DEF_OFF1;
            3'h2: v = `BMF_DEF_OFF2;
            3'h3: v = `BMF_DEF_OFF3;
            3'h4: v = `BMF_DEF_OFF4;
            3'h5: v = `BMF_DEF_OFF5;
            3'h6: v = `BMF_DEF_OFF6;
            3'h7: v = `BMF_DEF_OFF7;
        endcase
        return (v > DEPTH) ? CW'(DEPTH) : CW'(v);
    endfunction : def_off

    assign in_mrs   = !pins.master_reset_n;
    assign wr_req   = ce && !in_mrs && !pins.write_en_n;
    assign rd_req   = ce && !in_mrs && !pins.read_en_n;
    assign is_full  = (cnt_r == CW'(DEPTH));
    assign is_empty = (cnt_r == '0);
    assign wr_last  = (piece_pos(ww_r, widx_r, 1'b1) == piece_pos(ww_r, 2'h0, 1'b0));
    assign rd_last  = (piece_pos(rw_r, ridx_r, 1'b1) == piece_pos(rw_r, 2'h0, 1'b0));
    assign push     = wr_req && pins.offset_load_n && !is_full && wr_last;
    assign fetch    = ce && !in_mrs && pins.offset_load_n && !is_empty && (ft_r ? (!ov_r || rd_req) : rd_req);
    assign pop      = fetch && rd_last;

    // narrow piece placed into the assembly word, upper lines masked
    always_comb
    begin
        int pw;
        int sh;
        logic [35:0] m;
        pw = piece_w(ww_r);
        sh = pw * int'(piece_pos(ww_r, widx_r, be_r));
        m  = ((36'h1 << pw) - 36'h1);
        asm_nxt = (asm_r & ~(m << sh)) | ((pins.data_in_bus & m) << sh);
    end

    // parity positions stripped only for offset loads
    assign poff = ip_r ? {pins.data_in_bus[34:27], pins.data_in_bus[25:18], pins.data_in_bus[16:9],
                          pins.data_in_bus[7:0]} : pins.data_in_bus[31:0];

    // configuration latched while master reset held
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ft_r     <= 1'b0;
            be_r     <= 1'b0;
            ip_r     <= 1'b0;
            serial_r <= 1'b0;
            ww_r     <= BMF_X36;
            rw_r     <= BMF_X36;
        end
        else if (ce && in_mrs)
        begin
            ft_r     <= pins.fall_through_serial_in;
            be_r     <= pins.byte_order_sel;
            ip_r     <= pins.parity_placement_sel;
            serial_r <= pins.offset_load_n;
            ww_r     <= wsel(pins.width_match_sel, pins.write_width_sel, pins.read_width_sel, 1'b0);
            rw_r     <= wsel(pins.width_match_sel, pins.write_width_sel, pins.read_width_sel, 1'b1);
        end
    end

    // offset registers: defaults, serial shift, parallel load
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            eoff_r     <= def_off(3'h0);
            foff_r     <= def_off(3'h0);
            woff_sel_r <= 1'b0;
        end
        else if (ce && in_mrs)
        begin
            eoff_r     <= def_off({pins.offset_load_n, pins.default_offset_sel1, pins.default_offset_sel0});
            foff_r     <= def_off({pins.offset_load_n, pins.default_offset_sel1, pins.default_offset_sel0});
            woff_sel_r <= 1'b0;
        end
        else if (ce && !pins.offset_load_n)
        begin
            if (serial_r && !pins.serial_en_n)
            begin
                eoff_r <= {eoff_r[CW-2:0], foff_r[CW-1]};
                foff_r <= {foff_r[CW-2:0], pins.fall_through_serial_in};
            end
            else if (!serial_r && wr_req)
            begin
                if (woff_sel_r)
                    foff_r <= poff[CW-1:0];
                else
                    eoff_r <= poff[CW-1:0];
                woff_sel_r <= !woff_sel_r;
            end
        end
    end

    // write side: piece assembly and storage
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem[wp_r] <= asm_nxt;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wp_r   <= '0;
            widx_r <= 2'h0;
            asm_r  <= '0;
        end
        else if (ce && in_mrs)
        begin
            wp_r   <= '0;
            widx_r <= 2'h0;
            asm_r  <= '0;
        end
        else if (wr_req && pins.offset_load_n && !is_full)
        begin
            asm_r  <= wr_last ? '0 : asm_nxt;
            widx_r <= wr_last ? 2'h0 : widx_r + 2'h1;
            if (wr_last)
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
        end
    end

    // read side: pieces out, offsets out when load pin low
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rp_r       <= '0;
            ridx_r     <= 2'h0;
            dout_r     <= '0;
            ov_r       <= 1'b0;
            roff_sel_r <= 1'b0;
        end
        else if (ce && in_mrs)
        begin
            rp_r       <= '0;
            ridx_r     <= 2'h0;
            dout_r     <= '0;
            ov_r       <= 1'b0;
            roff_sel_r <= 1'b0;
        end
        else if (rd_req && !pins.offset_load_n)
        begin
            dout_r     <= 36'(roff_sel_r ? foff_r : eoff_r);
            roff_sel_r <= !roff_sel_r;
        end
        else if (fetch)
        begin
            dout_r <= (mem[rp_r] >> (piece_w(rw_r) * int'(piece_pos(rw_r, ridx_r, be_r))))
                      & ((36'h1 << piece_w(rw_r)) - 36'h1);
            ridx_r <= rd_last ? 2'h0 : ridx_r + 2'h1;
            if (rd_last)
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            ov_r   <= 1'b1;
        end
        else if (ft_r && rd_req && pins.offset_load_n)
            ov_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else if (ce && in_mrs)
            cnt_r <= '0;
        else if (push && !pop)
            cnt_r <= cnt_r + 1'b1;
        else if (pop && !push)
            cnt_r <= cnt_r - 1'b1;
    end

    // flags
    assign pins.empty_flag_n        = ft_r ? !ov_r : !is_empty;
    assign pins.full_flag_n         = ft_r ? is_full : !is_full;
    assign pins.half_full_flag_n    = !(cnt_r > CW'(DEPTH / 2));
    assign pins.almost_empty_flag_n = !(cnt_r < eoff_r);
    assign pins.almost_full_flag_n  = !((CW'(DEPTH) - cnt_r) <= foff_r);
    assign pins.data_out_bus        = dout_r;
    assign stored_words             = cnt_r;
    assign write_port_width         = ww_r;
    assign read_port_width          = rw_r;
endmodule : bmf_device
`default_nettype wire

// ### bmf_params.svh
/*
 bus-matching fifo: offsets, field positions, reset values and counts.
 assumes inclusion by bare name wherever a constant is needed.
*/
`ifndef BMF_PARAMS_SVH
`define BMF_PARAMS_SVH
`define BMF_DATA_W      36
`define BMF_DEPTH       1024
`define BMF_TXF_DEPTH   8
`define BMF_MRS_CYCLES  4
`define BMF_DEF_OFF0    7
`define BMF_DEF_OFF1    15
`define BMF_DEF_OFF2    31
`define BMF_DEF_OFF3    63
`define BMF_DEF_OFF4    127
`define BMF_DEF_OFF5    255
`define BMF_DEF_OFF6    511
`define BMF_DEF_OFF7    1023
`define BMF_REG_CONFIG  5'h00
`define BMF_REG_CONTROL 5'h04
`define BMF_REG_TXDATA  5'h08
`define BMF_REG_RXDATA  5'h0C
`define BMF_REG_STATUS  5'h10
`define BMF_REG_SERIAL  5'h14
`define BMF_CFG_RESET   9'h000
`define BMF_CFG_BM      0
`define BMF_CFG_IW      1
`define BMF_CFG_OW      2
`define BMF_CFG_BE      3
`define BMF_CFG_IP      4
`define BMF_CFG_FT      5
`define BMF_CFG_FS0     6
`define BMF_CFG_FS1     7
`define BMF_CFG_LD      8
`define BMF_CTL_MRS     0
`define BMF_CTL_OFFMODE 1
`endif

// ### bmf_pkg.sv
/*
 bus-matching fifo: shared types.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package bmf_pkg;
    typedef enum logic [1:0] {BMF_X36 = 2'b00, BMF_X18 = 2'b01, BMF_X9 = 2'b10} bmf_width_t;
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_RWAIT = 2'b01, H_RPULSE = 2'b10, H_RCAP = 2'b11} bmf_hstate_t;
endpackage : bmf_pkg
`default_nettype wire

// ### bmf_pins_if.sv
/*
 bus-matching fifo: pin bundle between fifo device and its controller.
 assumes one shared clock; all pins one-way.
*/
`timescale 1ns/100ps
`default_nettype none
interface bmf_pins_if;
    logic        master_reset_n;
    logic        width_match_sel;
    logic        write_width_sel;
    logic        read_width_sel;
    logic        byte_order_sel;
    logic        parity_placement_sel;
    logic        default_offset_sel0;
    logic        default_offset_sel1;
    logic        offset_load_n;
    logic        fall_through_serial_in;
    logic        serial_en_n;
    logic        write_en_n;
    logic        read_en_n;
    logic [35:0] data_in_bus;
    logic [35:0] data_out_bus;
    logic        empty_flag_n;
    logic        full_flag_n;
    logic        half_full_flag_n;
    logic        almost_empty_flag_n;
    logic        almost_full_flag_n;
    modport dev (input master_reset_n, width_match_sel, write_width_sel, read_width_sel, byte_order_sel,
                 parity_placement_sel, default_offset_sel0, default_offset_sel1, offset_load_n,
                 fall_through_serial_in, serial_en_n, write_en_n, read_en_n, data_in_bus,
                 output data_out_bus, empty_flag_n, full_flag_n, half_full_flag_n, almost_empty_flag_n,
                 almost_full_flag_n);
    modport host (output master_reset_n, width_match_sel, write_width_sel, read_width_sel, byte_order_sel,
                  parity_placement_sel, default_offset_sel0, default_offset_sel1, offset_load_n,
                  fall_through_serial_in, serial_en_n, write_en_n, read_en_n, data_in_bus,
                  input data_out_bus, empty_flag_n, full_flag_n, half_full_flag_n, almost_empty_flag_n,
                  almost_full_flag_n);
endinterface : bmf_pins_if
`default_nettype wire

// ### bmf_txfifo.sv
/*
 small synchronous fifo with valid/ready on both sides.
 assumes one clock; ce low freezes state.
*/
`timescale 1ns/100ps
`default_nettype none
module bmf_txfifo #(
    parameter int W = 36,
    parameter int D = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];
    assign push      = in_valid && in_ready && ce;
    assign pop       = out_valid && out_ready && ce;

    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem[wp_r] <= in_data;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule : bmf_txfifo
`default_nettype wire

// ### bmf_host.sv
/*
 bus-matching fifo controller: avalon-mm slave driving the fifo pins.
 assumes device pins on the same clock; tx words buffered in a small fifo.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bmf_params.svh"
module bmf_host #(
    parameter int TXF_DEPTH = `BMF_TXF_DEPTH
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    bmf_pins_if.host          pins,
    input  wire logic [4:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    output bmf_pkg::bmf_hstate_t rd_state
);
    import bmf_pkg::*;
    logic [8:0]  cfg_r;
    logic        offmode_r;
    logic [3:0]  mrs_cnt_r;
    logic        sbit_r;
    logic        sen_n_r;
    logic        wen_n_r;
    logic        ren_n_r;
    logic [35:0] din_r;
    logic [31:0] rdata_r;
    logic        rdv_r;
    bmf_hstate_t st_r;
    logic        busy;
    logic        tx_in_ready;
    logic        tx_valid;
    logic [31:0] tx_data;
    logic        drain;
    logic        room;
    logic        avail;
    logic        wr_tx;

    assign busy  = (mrs_cnt_r != 4'h0);
    assign wr_tx = avs_write && (avs_address == `BMF_REG_TXDATA);
    assign room  = cfg_r[`BMF_CFG_FT] ? !pins.full_flag_n : pins.full_flag_n;
    assign avail = cfg_r[`BMF_CFG_FT] ? !pins.empty_flag_n : pins.empty_flag_n;
    assign drain = ce && tx_valid && wen_n_r && !busy && (room || offmode_r);

    bmf_txfifo #(.W(32), .D(TXF_DEPTH)) u_txf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .in_data   (avs_writedata),
        .in_valid  (wr_tx),
        .in_ready  (tx_in_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (drain)
    );

    assign avs_waitrequest = (avs_read && !rdv_r) || (wr_tx && !tx_in_ready);
    assign avs_readdata    = rdata_r;
    assign rd_state        = st_r;

    // configuration pins held steady, reset-time levels while busy
    assign pins.master_reset_n         = !busy;
    assign pins.width_match_sel        = cfg_r[`BMF_CFG_BM];
    assign pins.write_width_sel        = cfg_r[`BMF_CFG_IW];
    assign pins.read_width_sel         = cfg_r[`BMF_CFG_OW];
    assign pins.byte_order_sel         = cfg_r[`BMF_CFG_BE];
    assign pins.parity_placement_sel   = cfg_r[`BMF_CFG_IP];
    assign pins.default_offset_sel0    = cfg_r[`BMF_CFG_FS0];
    assign pins.default_offset_sel1    = cfg_r[`BMF_CFG_FS1];
    assign pins.offset_load_n          = busy ? cfg_r[`BMF_CFG_LD] : !offmode_r;
    assign pins.fall_through_serial_in = busy ? cfg_r[`BMF_CFG_FT] : sbit_r;
    assign pins.serial_en_n            = sen_n_r;
    assign pins.write_en_n             = wen_n_r;
    assign pins.read_en_n              = ren_n_r;
    assign pins.data_in_bus            = din_r;

    // register writes and master reset sequencing
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_r     <= `BMF_CFG_RESET;
            offmode_r <= 1'b0;
            mrs_cnt_r <= 4'(`BMF_MRS_CYCLES);
            sbit_r    <= 1'b0;
            sen_n_r   <= 1'b1;
        end
        else if (ce)
        begin
            sen_n_r <= 1'b1;
            if (busy)
                mrs_cnt_r <= mrs_cnt_r - 4'h1;
            if (avs_write && avs_address == `BMF_REG_CONFIG)
                cfg_r <= avs_writedata[8:0];
            if (avs_write && avs_address == `BMF_REG_CONTROL)
            begin
                offmode_r <= avs_writedata[`BMF_CTL_OFFMODE];
                if (avs_writedata[`BMF_CTL_MRS])
                    mrs_cnt_r <= 4'(`BMF_MRS_CYCLES);
            end
            if (avs_write && avs_address == `BMF_REG_SERIAL && !busy)
            begin
                sbit_r  <= avs_writedata[0];
                sen_n_r <= 1'b0;
            end
        end
    end

    // tx drain, one write at most every other cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wen_n_r <= 1'b1;
            din_r   <= '0;
        end
        else if (ce)
        begin
            wen_n_r <= !drain;
            if (drain)
                din_r <= {4'h0, tx_data};
        end
    end

    // register reads and the device read sequence
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r    <= H_IDLE;
            ren_n_r <= 1'b1;
            rdata_r <= '0;
            rdv_r   <= 1'b0;
        end
        else if (ce)
        begin
            if (avs_read && rdv_r)
                rdv_r <= 1'b0;
            unique case (st_r)
                H_IDLE:
                begin
                    if (avs_read && !rdv_r && avs_address == `BMF_REG_RXDATA)
                        st_r <= H_RWAIT;
                    else if (avs_read && !rdv_r)
                    begin
                        rdv_r <= 1'b1;
                        unique case (avs_address)
                            `BMF_REG_CONFIG:  rdata_r <= {23'h0, cfg_r};
                            `BMF_REG_CONTROL: rdata_r <= {30'h0, offmode_r, busy};
                            `BMF_REG_STATUS:  rdata_r <= {25'h0, tx_valid, busy, pins.almost_full_flag_n,
                                                          pins.almost_empty_flag_n, pins.half_full_flag_n,
                                                          pins.full_flag_n, pins.empty_flag_n};
                            default:          rdata_r <= '0;
                        endcase
                    end
                end
                H_RWAIT:
                begin
                    if (!busy && cfg_r[`BMF_CFG_FT] && !offmode_r && avail)
                    begin
                        rdata_r <= pins.data_out_bus[31:0];
                        ren_n_r <= 1'b0;
                        rdv_r   <= 1'b1;
                        st_r    <= H_RCAP;
                    end
                    else if (!busy && (avail || offmode_r))
                    begin
                        ren_n_r <= 1'b0;
                        st_r    <= H_RPULSE;
                    end
                end
                H_RPULSE:
                begin
                    ren_n_r <= 1'b1;
                    st_r    <= H_RCAP;
                end
                H_RCAP:
                begin
                    ren_n_r <= 1'b1;
                    st_r    <= H_IDLE;
                    if (!rdv_r)
                    begin
                        rdata_r <= pins.data_out_bus[31:0];
                        rdv_r   <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : bmf_host
`default_nettype wire

// ### bmf_pins_sva.sv
/*
 checks on the fifo pin bundle.
 assumes ce tied high and one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module bmf_pins_sva (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        master_reset_n,
    input wire logic        fall_through_serial_in,
    input wire logic        write_en_n,
    input wire logic        read_en_n,
    input wire logic [35:0] data_out_bus,
    input wire logic        empty_flag_n,
    input wire logic        full_flag_n,
    input wire logic        half_full_flag_n,
    input wire logic        almost_empty_flag_n
);
    logic ft_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // timing mode seen during master reset
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            ft_r <= 1'b0;
        else if (!master_reset_n)
            ft_r <= fall_through_serial_in;
    sequence mrs_done_s;
        !master_reset_n ##1 master_reset_n;
    endsequence
    ef_std_a: assert property (mrs_done_s ##0 !ft_r |-> !empty_flag_n) else $error("ef reset");
    ef_ft_a: assert property (mrs_done_s ##0 ft_r |-> empty_flag_n) else $error("or reset");
    ff_std_a: assert property (mrs_done_s ##0 !ft_r |-> full_flag_n) else $error("ff reset");
    ff_ft_a: assert property (mrs_done_s ##0 ft_r |-> !full_flag_n) else $error("ir reset");
    hf_reset_a: assert property (mrs_done_s |-> half_full_flag_n) else $error("hf reset");
    ae_reset_a: assert property (mrs_done_s |-> !almost_empty_flag_n) else $error("ae reset");
    hf_hold_a: assert property (master_reset_n && write_en_n && read_en_n && !ft_r
        |=> $stable(half_full_flag_n)) else $error("hf moved");
    dout_hold_a: assert property (master_reset_n && read_en_n && !ft_r
        |=> $stable(data_out_bus)) else $error("dout moved");
endmodule : bmf_pins_sva
`default_nettype wire

// ### tb_top.sv
/*
 testbench: controller and fifo joined by the pin bundle, driven over avalon.
 assumes checker and design files compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bmf_params.svh"
module tb_top;
    import bmf_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    bmf_width_t  wp;
    bmf_width_t  rp;
    logic [31:0] q;
    int          errors = 0;
    int          checked = 0;
    logic [8:0]  cfgs [5] = '{9'h000, 9'h001, 9'h005, 9'h003, 9'h007};
    logic [3:0]  exps [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    always #4 ref_clk = ~ref_clk;
    bmf_pins_if i_bmf_pins_if ();
    bmf_device #(.DEPTH(16)) i_bmf_device (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .pins(i_bmf_pins_if.dev),
        .stored_words(), .write_port_width(wp), .read_port_width(rp));
    bmf_host i_bmf_host (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .pins(i_bmf_pins_if.host), .rd_state(),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    bmf_pins_sva i_bmf_pins_sva (.ref_clk(ref_clk), .rst(rst), .master_reset_n(i_bmf_pins_if.master_reset_n),
        .fall_through_serial_in(i_bmf_pins_if.fall_through_serial_in), .write_en_n(i_bmf_pins_if.write_en_n),
        .read_en_n(i_bmf_pins_if.read_en_n), .data_out_bus(i_bmf_pins_if.data_out_bus),
        .empty_flag_n(i_bmf_pins_if.empty_flag_n), .full_flag_n(i_bmf_pins_if.full_flag_n),
        .half_full_flag_n(i_bmf_pins_if.half_full_flag_n), .almost_empty_flag_n(i_bmf_pins_if.almost_empty_flag_n));
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : acc
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [35:0] e);
        acc(1'b0, a, 32'h0);
        chk({4'h0, q}, e);
    endtask : rd
    task automatic cfg(input logic [8:0] c);
        acc(1'b1, `BMF_REG_CONFIG, {23'h0, c});
        acc(1'b1, `BMF_REG_CONTROL, 32'h1);
        do acc(1'b0, `BMF_REG_CONTROL, 32'h0); while (q[0] !== 1'b0);
    endtask : cfg
    task automatic summarize();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (cfgs[i])
        begin
            cfg(cfgs[i]);
            chk({32'h0, wp, rp}, {32'h0, exps[i]});
        end
        for (int k = 0; k < 4; k++)
            acc(1'b1, `BMF_REG_TXDATA, 32'hFFFFFE00 | (k + 1));
        rd(`BMF_REG_RXDATA, {4'h0, 32'({9'h1, 9'h2, 9'h3, 9'h4})});
        for (int b = 0; b < 2; b++)
        begin
            cfg(9'h005 | 9'(b << 3));
            acc(1'b1, `BMF_REG_TXDATA, 32'h11223344);
            for (int k = 0; k < 4; k++)
                rd(`BMF_REG_RXDATA, (36'h011223344 >> (b ? 9 * k : 27 - 9 * k)) & 36'h1FF);
        end
        cfg(9'h000);
        rd(`BMF_REG_STATUS, 36'h16);
        for (int k = 0; k < 16; k++)
            acc(1'b1, `BMF_REG_TXDATA, k);
        do acc(1'b0, `BMF_REG_STATUS, 32'h0); while (q[6] !== 1'b0);
        rd(`BMF_REG_STATUS, 36'h09);
        for (int k = 0; k < 16; k++)
            rd(`BMF_REG_RXDATA, k);
        rd(`BMF_REG_STATUS, 36'h16);
        acc(1'b1, `BMF_REG_CONTROL, 32'h2);
        rd(`BMF_REG_RXDATA, 36'h7);
        rd(`BMF_REG_RXDATA, 36'h7);
        acc(1'b1, `BMF_REG_CONTROL, 32'h0);
        cfg(9'h010);
        acc(1'b1, `BMF_REG_TXDATA, 32'h105);
        rd(`BMF_REG_RXDATA, 36'h105);
        acc(1'b1, `BMF_REG_CONTROL, 32'h2);
        acc(1'b1, `BMF_REG_TXDATA, 32'h10A);
        acc(1'b1, `BMF_REG_TXDATA, 32'h0C);
        rd(`BMF_REG_RXDATA, 36'h0A);
        rd(`BMF_REG_RXDATA, 36'h0C);
        cfg(9'h100);
        acc(1'b1, `BMF_REG_CONTROL, 32'h2);
        rd(`BMF_REG_RXDATA, 36'h10);
        rd(`BMF_REG_RXDATA, 36'h10);
        for (int k = 9; k >= 0; k--)
            acc(1'b1, `BMF_REG_SERIAL, 32'(10'h065 >> k) & 32'h1);
        rd(`BMF_REG_RXDATA, 36'h03);
        rd(`BMF_REG_RXDATA, 36'h05);
        cfg(9'h020);
        rd(`BMF_REG_STATUS, 36'h15);
        acc(1'b1, `BMF_REG_TXDATA, 32'h5A5);
        rd(`BMF_REG_RXDATA, 36'h5A5);
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
